// [shared/insn_decode_pkg.sv]
// Field layouts, opcode codes and class enumerations for the instruction decoder.
package insn_decode_pkg;

	localparam int WORD_W = 14;
	localparam int FILE_ADDR_W = 7;
	localparam int BIT_ADDR_W = 6;
	localparam int REG_ADDR_W = 8;
	localparam int LIT_W = 8;
	localparam int TARGET_W = 12;
	localparam int BITPOS_W = 3;

	// Field positions inside the 14-bit word.
	localparam int OP6_LSB = 8;
	localparam int DEST_POS = 7;
	localparam int BITPOS_LSB = 6;
	localparam int OP5_LSB = 9;
	localparam int TOP2_LSB = 12;

	// Two top bits select the broad class.
	localparam logic [1:0] TOP_BYTE = 2'h0;
	localparam logic [1:0] TOP_MIXED = 2'h1;
	localparam logic [1:0] TOP_CALL = 2'h2;
	localparam logic [1:0] TOP_GOTO = 2'h3;

	// Six-bit opcodes of the second-plane moves; other 01_1xxx codes are literal.
	localparam logic [5:0] OP_MOVE_FROM_R = 6'h1f;
	localparam logic [5:0] OP_MOVE_TO_R = 6'h1e;
	// Control words that share the move-to-second-plane opcode.
	localparam logic [13:0] WORD_SLEEP = 14'h1e03;
	localparam logic [13:0] WORD_CLRWDOG = 14'h1e04;

	// Destination select codes.
	localparam logic DEST_ACC = 1'b0;
	localparam logic DEST_FILE = 1'b1;

	typedef enum logic [1:0] {
		CLASS_BYTE,
		CLASS_BIT,
		CLASS_LITCTL
	} insn_class_e;

	typedef enum logic [1:0] {
		PLANE_NONE,
		PLANE_F,
		PLANE_R
	} plane_e;

	typedef enum logic [1:0] {
		LIT_NONE,
		LIT_IMM,
		LIT_CALL,
		LIT_JUMP
	} lit_kind_e;

endpackage : insn_decode_pkg

// [design/bit_mask_gen.sv]
// One-hot mask generator for the bit-position field.
`timescale 1ns/10ps
module bit_mask_gen
	import insn_decode_pkg::*;
#(
	parameter int POS_W = BITPOS_W
)
(
	input wire logic [POS_W-1:0] pos,
	output logic [(1<<POS_W)-1:0] mask
);

	// One bit of the mask per register bit position.
	genvar gi;
	generate
		for (gi = 0; gi < (1 << POS_W); gi++)
		begin : g_bit
			assign mask[gi] = (pos == POS_W'(gi));
		end
	endgenerate

endmodule : bit_mask_gen

// [design/instruction_word_decoder.sv]
// Registered decoder for 14-bit instruction words of the small core.
//
// What this block does
// - Each word is one 14-bit unit: an opcode plus one or more operands.
// - Every opcode falls in the byte, bit or literal/control class.
// - A byte operation with select 0 writes the accumulator, 1 the file.
// - A bit operation picks one bit of the register by its position field.
// - Register operands go to the primary or the secondary plane.
// - Literal/control operands are immediates or jump targets, not addresses.
// - The destination field is one bit: 0 working register, 1 register file.
// - Byte words: six-bit opcode, select bit, seven-bit address 00h-7Fh.
// - Bit words: five-bit opcode, three-bit position, six-bit address.
// - Literal words: six-bit opcode above an eight-bit immediate.
`timescale 1ns/10ps
module instruction_word_decoder
	import insn_decode_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic word_valid,
	input wire logic [WORD_W-1:0] word,
	output logic dec_valid,
	output insn_class_e dec_class,
	output logic [5:0] dec_opcode,
	output plane_e dec_plane,
	output logic [REG_ADDR_W-1:0] dec_reg_addr,
	output logic dec_to_acc,
	output logic dec_to_file,
	output logic [BITPOS_W-1:0] dec_bit_pos,
	output logic [(1<<BITPOS_W)-1:0] dec_bit_mask,
	output lit_kind_e dec_lit_kind,
	output logic [LIT_W-1:0] dec_literal,
	output logic [TARGET_W-1:0] dec_target,
	output logic dec_sleep,
	output logic dec_clr_watchdog
);

	////////////////////////////////////////////////////////////////////////
	// Field split, combinational.

	logic [1:0] top2;
	logic [5:0] op6;
	logic [4:0] op5;
	logic [(1<<BITPOS_W)-1:0] mask_c;
	insn_class_e class_next;
	plane_e plane_next;
	lit_kind_e lit_next;
	logic [REG_ADDR_W-1:0] addr_next;
	logic to_file_next;

	// The word is always taken whole; fields are slices of it.
	assign top2 = word[WORD_W-1:TOP2_LSB];
	assign op6 = word[WORD_W-1:OP6_LSB];
	assign op5 = word[WORD_W-1:OP5_LSB];

	bit_mask_gen #(
		.POS_W(BITPOS_W)
	) u_mask (
		.pos(word[BITPOS_LSB +: BITPOS_W]),
		.mask(mask_c)
	);

	// Class, plane, literal kind and address by opcode group. The two
	// secondary-plane moves sit inside the 01_1xxx literal range, so they
	// are matched before the literal default; the sleep and watchdog
	// words share the move-to opcode and are caught first.
	always_comb
	begin
		class_next = CLASS_LITCTL;
		plane_next = PLANE_NONE;
		lit_next = LIT_NONE;
		addr_next = '0;
		to_file_next = 1'b0;
		unique case (top2)
			TOP_BYTE:
			begin
				class_next = CLASS_BYTE;
				plane_next = PLANE_F;
				addr_next = {1'b0, word[FILE_ADDR_W-1:0]};
				to_file_next = word[DEST_POS];
			end
			TOP_MIXED:
			begin
				// Bit 11 clear marks the bit class; set means literal or move.
				if (!word[TOP2_LSB - 1])
				begin
					class_next = CLASS_BIT;
					plane_next = PLANE_F;
					addr_next = {2'h0, word[BIT_ADDR_W-1:0]};
					to_file_next = 1'b1;
				end
				else if (word == WORD_SLEEP || word == WORD_CLRWDOG)
				begin
					class_next = CLASS_LITCTL;
				end
				else if (op6 == OP_MOVE_FROM_R || op6 == OP_MOVE_TO_R)
				begin
					class_next = CLASS_BYTE;
					plane_next = PLANE_R;
					addr_next = word[REG_ADDR_W-1:0];
					to_file_next = (op6 == OP_MOVE_TO_R);
				end
				else
				begin
					lit_next = LIT_IMM;
				end
			end
			TOP_CALL:
			begin
				lit_next = LIT_CALL;
			end
			TOP_GOTO:
			begin
				lit_next = LIT_JUMP;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs, one cycle after the word is accepted.

	// Valid follows the input strobe by one cycle.
	always_ff @(posedge clk)
	begin
		if (reset)
			dec_valid <= 1'b0;
		else
			dec_valid <= word_valid;
	end

	// Decoded fields hold until the next valid word so that idle cycles
	// do not disturb a consumer that samples late.
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dec_class <= CLASS_LITCTL;
			dec_opcode <= '0;
			dec_plane <= PLANE_NONE;
			dec_reg_addr <= '0;
			dec_to_acc <= 1'b0;
			dec_to_file <= 1'b0;
			dec_bit_pos <= '0;
			dec_bit_mask <= '0;
			dec_lit_kind <= LIT_NONE;
			dec_literal <= '0;
			dec_target <= '0;
			dec_sleep <= 1'b0;
			dec_clr_watchdog <= 1'b0;
		end
		else if (word_valid)
		begin
			dec_class <= class_next;
			dec_opcode <= (class_next == CLASS_BIT) ? {1'b0, op5} : op6;
			dec_plane <= plane_next;
			dec_reg_addr <= addr_next;
			// Only byte-class results have a choice of destination.
			dec_to_acc <= (class_next == CLASS_BYTE) &&
				(to_file_next == DEST_ACC);
			dec_to_file <= (class_next != CLASS_LITCTL) &&
				(to_file_next == DEST_FILE);
			dec_bit_pos <= (class_next == CLASS_BIT) ?
				word[BITPOS_LSB +: BITPOS_W] : '0;
			dec_bit_mask <= (class_next == CLASS_BIT) ? mask_c : '0;
			dec_lit_kind <= lit_next;
			dec_literal <= (lit_next == LIT_IMM) ?
				word[LIT_W-1:0] : '0;
			dec_target <= (lit_next == LIT_CALL || lit_next == LIT_JUMP) ?
				word[TARGET_W-1:0] : '0;
			dec_sleep <= (word == WORD_SLEEP);
			dec_clr_watchdog <= (word == WORD_CLRWDOG);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_word_in(logic [1:0] t);
		word_valid && top2 == t;
	endsequence

	a_byte_dest_route: assert property (@(posedge clk) disable iff (reset)
		s_word_in(TOP_BYTE) |=> dec_class == CLASS_BYTE &&
		dec_to_file == $past(word[DEST_POS]) &&
		dec_to_acc == !$past(word[DEST_POS]))
		else $error("byte destination misrouted");

	a_dest_onehot: assert property (@(posedge clk) disable iff (reset)
		!(dec_to_acc && dec_to_file))
		else $error("both destinations selected");

	a_byte_addr_field: assert property (@(posedge clk) disable iff (reset)
		s_word_in(TOP_BYTE) |=> dec_reg_addr == {1'b0, $past(word[6:0])}
		&& dec_plane == PLANE_F)
		else $error("byte address field wrong");

	a_bit_fields: assert property (@(posedge clk) disable iff (reset)
		word_valid && word[13:11] == 3'h2 |=> dec_class == CLASS_BIT &&
		dec_reg_addr == {2'h0, $past(word[5:0])} &&
		dec_bit_mask == (8'h01 << $past(word[8:6])))
		else $error("bit operand fields wrong");

	a_bit_pos_match: assert property (@(posedge clk) disable iff (reset)
		dec_class == CLASS_BIT |-> dec_bit_mask[dec_bit_pos])
		else $error("bit mask disagrees with position");

	a_lit_immediate: assert property (@(posedge clk) disable iff (reset)
		word_valid && word[13:11] == 3'h3 && word[13:9] != 5'h0f
		|=> dec_lit_kind == LIT_IMM && dec_plane == PLANE_NONE &&
		dec_literal == $past(word[7:0]))
		else $error("literal immediate wrong");

	a_jump_target: assert property (@(posedge clk) disable iff (reset)
		word_valid && word[13] |=> dec_class == CLASS_LITCTL &&
		dec_target == $past(word[11:0]) && !dec_to_file)
		else $error("jump target wrong");

	a_second_plane: assert property (@(posedge clk) disable iff (reset)
		word_valid && word[13:8] == 6'h1f |=> dec_plane == PLANE_R &&
		dec_reg_addr == $past(word[7:0]) && dec_to_acc)
		else $error("second plane move wrong");

	a_valid_delay: assert property (@(posedge clk) disable iff (reset)
		word_valid |=> dec_valid ##0 (dec_class != CLASS_BIT ||
		$past(top2) == TOP_MIXED))
		else $error("decode not one cycle after word");

	a_word_whole: assert property (@(posedge clk) disable iff (reset)
		!word_valid |=> $stable(dec_class) && !dec_valid)
		else $error("outputs moved without a word");

endmodule : instruction_word_decoder

// [dv/prog_rom.sv]
// Program memory model that hands instruction words to the decoder.
`timescale 1ns/10ps
module prog_rom
	import insn_decode_pkg::*;
(
	input wire logic [5:0] idx,
	output logic [WORD_W-1:0] word
);
	// Words are built from fields so one index walks a whole class.
	always_comb
	begin
		if (idx[5])
			word = {3'h2, idx[4:3], idx[2:0], 6'h2a};
		else if (idx[4])
			word = {2'h0, idx[3:0], ~idx[0], {7{idx[1]}}};
		else
			case (idx[3:0])
				4'h0: word = 14'h1fa5;
				4'h1: word = 14'h1e3c;
				4'h2: word = 14'h1c5a;
				4'h3: word = 14'h2abc;
				4'h4: word = 14'h3123;
				4'h5: word = WORD_SLEEP;
				4'h6: word = WORD_CLRWDOG;
				default: word = 14'h0000;
			endcase
	end
endmodule : prog_rom

// [dv/instruction_word_decoder_tb.sv]
// Self-checking bench for the instruction word decoder.
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
$display("wrong value %s expected %h seen %h", n, e, g); end end
module instruction_word_decoder_tb;
	import insn_decode_pkg::*;
	logic clk = 0, reset = 1, word_valid = 0, dec_valid, to_acc, to_file;
	logic sleep, clr_wd;
	logic [5:0] idx = 0, opcode;
	logic [WORD_W-1:0] word;
	insn_class_e cls;
	plane_e plane;
	lit_kind_e lk;
	logic [7:0] addr, mask, lit;
	logic [2:0] pos;
	logic [11:0] tgt;
	int failures = 0, comparisons = 0;
	prog_rom prog_rom_i (.idx(idx), .word(word));
	instruction_word_decoder instruction_word_decoder_i (.clk(clk),
		.reset(reset), .word_valid(word_valid), .word(word),
		.dec_valid(dec_valid), .dec_class(cls), .dec_opcode(opcode),
		.dec_plane(plane), .dec_reg_addr(addr), .dec_to_acc(to_acc),
		.dec_to_file(to_file), .dec_bit_pos(pos), .dec_bit_mask(mask),
		.dec_lit_kind(lk), .dec_literal(lit), .dec_target(tgt),
		.dec_sleep(sleep), .dec_clr_watchdog(clr_wd));
	// Free-running 8 ns clock.
	initial
	begin
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	// Presents one word for one cycle; the answer is read a cycle on.
	task issue(input logic [5:0] i);
		@(negedge clk);
		idx = i;
		word_valid = 1;
		@(negedge clk);
		word_valid = 0;
		`CHK("valid", 1'b1, dec_valid)
	endtask : issue
	// Byte words at both address ends and with both destinations.
	task byte_ops;
		for (int i = 16; i < 32; i++)
		begin
			issue(6'(i));
			`CHK("class", CLASS_BYTE, cls)
			`CHK("opcode", 6'(i - 16), opcode)
			`CHK("plane", PLANE_F, plane)
			`CHK("addr", {1'b0, {7{i[1]}}}, addr)
			`CHK("acc", i[0], to_acc)
			`CHK("file", ~i[0], to_file)
		end
	endtask : byte_ops
	// All four bit operations at every bit position.
	task bit_ops;
		for (int i = 32; i < 64; i++)
		begin
			issue(6'(i));
			`CHK("class", CLASS_BIT, cls)
			`CHK("opcode", {4'h2, i[4:3]}, opcode)
			`CHK("plane", PLANE_F, plane)
			`CHK("file", 1'b1, to_file)
			`CHK("pos", i[2:0], pos)
			`CHK("mask", 8'h01 << i[2:0], mask)
			`CHK("addr", 8'h2a, addr)
		end
	endtask : bit_ops
	// Secondary plane moves in both directions.
	task plane_moves;
		issue(6'h00);
		`CHK("plane", PLANE_R, plane)
		`CHK("addr", 8'ha5, addr)
		`CHK("acc", 1'b1, to_acc)
		issue(6'h01);
		`CHK("addr", 8'h3c, addr)
		`CHK("file", 1'b1, to_file)
	endtask : plane_moves
	// Immediate and call back to back, an idle hold, then jump, sleep and watchdog.
	task literals;
		@(negedge clk);
		idx = 6'h02;
		word_valid = 1;
		@(negedge clk);
		idx = 6'h03;
		`CHK("class", CLASS_LITCTL, cls)
		`CHK("kind", LIT_IMM, lk)
		`CHK("lit", 8'h5a, lit)
		`CHK("plane", PLANE_NONE, plane)
		@(negedge clk);
		word_valid = 0;
		`CHK("call", {LIT_CALL, 12'habc}, {lk, tgt})
		@(negedge clk);
		`CHK("idle", 13'habc, {dec_valid, tgt})
		issue(6'h04);
		`CHK("jump", {LIT_JUMP, 12'h123}, {lk, tgt})
		issue(6'h05);
		`CHK("sleep", 2'h2, {sleep, clr_wd})
		issue(6'h06);
		`CHK("wdog", 2'h1, {sleep, clr_wd})
	endtask : literals
	// Prints the verdict and ends the run.
	task final_report;
		if (failures == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	// Main sequence; every wait is a fixed cycle count.
	initial
	begin
		repeat (5) @(negedge clk);
		reset = 0;
		`CHK("reset", {1'b0, CLASS_LITCTL}, {dec_valid, cls})
		byte_ops();
		bit_ops();
		plane_moves();
		literals();
		final_report();
	end
endmodule : instruction_word_decoder_tb
